// File: common/memif_hold_pkg.sv
// Shared constants and types for the memory bus hold handshake block
package memif_hold_pkg;

  // Bus widths of the two memory interface instances
  localparam int WIDE_DATA_W    = 64;
  localparam int NARROW_DATA_W  = 16;
  localparam int WIDE_BE_W      = 8;
  localparam int NARROW_BE_W    = 2;
  localparam int ADDR_W         = 20;
  localparam int CE_W           = 4;

  // Handshake timing in memory-clock periods, as documented
  localparam int FLOAT_MIN_E    = 2;
  localparam int REDRIVE_MIN_E  = 2;
  localparam int REDRIVE_MAX_E  = 7;
  localparam int GRANT_MAX_E    = 2;
  // Stages of the hold request synchroniser
  localparam int SYNC_STAGES    = 2;

  // Internal command codes
  typedef enum logic [2:0] {
    CMD_NOP        = 3'h0,
    CMD_ACTIVATE   = 3'h1,
    CMD_READ       = 3'h2,
    CMD_WRITE      = 3'h3,
    CMD_PRECHARGE  = 3'h4,
    CMD_REFRESH    = 3'h5,
    CMD_MODE_SET   = 3'h6,
    CMD_SELF_REF   = 3'h7
  } cmd_e;

  // SDRAM strobe patterns, ordered {row, column, write}, active low
  localparam logic [2:0] STB_NOP       = 3'h7;
  localparam logic [2:0] STB_ACTIVATE  = 3'h3;
  localparam logic [2:0] STB_READ      = 3'h5;
  localparam logic [2:0] STB_WRITE     = 3'h4;
  localparam logic [2:0] STB_PRECHARGE = 3'h2;
  localparam logic [2:0] STB_REFRESH   = 3'h1;
  localparam logic [2:0] STB_MODE_SET  = 3'h0;

  // Hold handshake states, one-hot
  typedef enum logic [3:0] {
    ST_RUN     = 4'h1,
    ST_FLOAT   = 4'h2,
    ST_GRANTED = 4'h4,
    ST_REDRIVE = 4'h8
  } hold_state_e;

endpackage

// File: verilog/external_bus_hold_handshake.sv
// Memory bus hold handshake, SDRAM strobe driver and bus-request output
//
// Operation
// - SDRAM accesses use shared strobes as column, write and row strobe.
// - Pending memory transactions finish before hold grant is given.
// - Idle bus is granted at minimum latency, no extra wait cycles.
// - Bus outputs float no sooner than two clocks after hold low.
// - Grant goes low after release, within two clocks of floating.
// - Bus driven again two to seven clocks after hold returns high.
// - Grant returns high within two clocks after bus is driven.
// - Float bit chooses: output clock toggles (0) or floats (1).
// - Floating clock goes off no sooner than two clocks after hold low.
// - Floating clock redriven two to seven clocks after hold high.
// - Hold inhibit set postpones the grant indefinitely.
// - Hold releases enables, data, address, strobes, clock enable, etc.
// - Only the wide instance performs self-refresh entry and exit.
// - Both instances can issue auto-refresh commands.
// - Both instances can issue mode-register-set commands.
// - Bus-request output updates on the output clock rising edge.
`timescale 1ns/1ps
`default_nettype none

module external_bus_hold_handshake
  import memif_hold_pkg::*;
#(
  parameter bit WIDE = 1'b1,
  localparam int DW  = WIDE ? WIDE_DATA_W : NARROW_DATA_W,
  localparam int BW  = WIDE ? WIDE_BE_W : NARROW_BE_W
) (
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire logic              i_link_clk,
  input  wire logic              i_link_reset,
  // Outside master handshake
  input  wire logic              i_hold_req_n,
  output logic                   o_bus_hold_grant_n,
  output logic                   o_pending_access_request,
  // Controls
  input  wire logic              i_hold_inhibit,
  input  wire logic              i_clkout_float_in_hold,
  // Internal command port
  input  wire logic              i_cmd_valid,
  input  wire logic [2:0]        i_cmd,
  input  wire logic [ADDR_W-1:0] i_cmd_addr,
  input  wire logic [DW-1:0]     i_cmd_wdata,
  input  wire logic [BW-1:0]     i_cmd_be,
  input  wire logic [CE_W-1:0]   i_cmd_ce,
  input  wire logic              i_cmd_pdt,
  input  wire logic              i_access_busy,
  output logic                   o_cmd_ready,
  output logic                   o_self_refresh,
  output logic [DW-1:0]          o_rd_data,
  // Memory bus pins
  output logic [CE_W-1:0]        o_chip_en_n,
  output logic [BW-1:0]          o_byte_en_n,
  output logic [ADDR_W-1:0]      o_addr,
  output logic [DW-1:0]          o_data_out,
  output logic                   o_data_oe,
  input  wire logic [DW-1:0]     i_data_in,
  output logic                   o_row_strobe_n,
  output logic                   o_column_strobe_n,
  output logic                   o_sdram_write_strobe_n,
  output logic                   o_sdram_clock_enable,
  output logic                   o_second_output_enable_n,
  output logic                   o_peripheral_direct_transfer_strobe_n,
  output logic                   o_bus_oe,
  output logic                   o_memif_clock_output,
  output logic                   o_memif_clock_output_oe
);

  hold_state_e       state_q;
  hold_state_e       state_d;
  logic              hold_meta_q;
  logic              hold_sync_q;
  logic              bus_oe_q;
  logic              clk_oe_q;
  logic              grant_n_q;
  logic [2:0]        stb_q;
  logic [2:0]        stb_d;
  logic              cke_q;
  logic              cke_d;
  logic              selfref_q;
  logic              selfref_d;
  logic              wr_q;
  logic [CE_W-1:0]   ce_n_q;
  logic [BW-1:0]     be_n_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DW-1:0]     wdata_q;
  logic              pdt_n_q;
  logic              soe_n_q;
  logic [DW-1:0]     rd_meta_q;
  logic [DW-1:0]     rd_q;
  logic              pending_q;
  logic              req_meta_q;
  logic              req_sync_q;

  // Named decode of the handshake conditions
  wire hold_low   = ~hold_sync_q;
  wire in_run     = (state_q == ST_RUN);
  wire cmd_legal  = (i_cmd != CMD_SELF_REF) || WIDE;
  wire cmd_fire   = i_cmd_valid & o_cmd_ready;
  wire is_self    = (i_cmd == CMD_SELF_REF);
  wire is_write   = (i_cmd == CMD_WRITE);
  wire may_grant  = hold_low & ~i_hold_inhibit & ~i_access_busy;
  wire pending    = i_cmd_valid | i_access_busy;

  // New commands are refused while the master asks for the bus
  assign o_cmd_ready = in_run & ~hold_low & cmd_legal;

  // Hold request synchroniser; the first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      hold_meta_q <= 1'b1;
      hold_sync_q <= 1'b1;
    end else begin
      hold_meta_q <= i_hold_req_n;
      hold_sync_q <= hold_meta_q;
    end
  end

  // Handshake sequencing: float, grant, then redrive and release grant on the same edge
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN: begin
        // Idle bus moves on the very edge the request is seen
        if (may_grant) begin
          state_d = ST_FLOAT;
        end
      end
      ST_FLOAT: begin
        state_d = ST_GRANTED;
      end
      ST_GRANTED: begin
        if (~hold_low) begin
          state_d = ST_REDRIVE;
        end
      end
      ST_REDRIVE: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Pin enables and grant are registered from the next state, so they change on the same edge as the state
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus_oe_q  <= 1'b1;
      clk_oe_q  <= 1'b1;
      grant_n_q <= 1'b1;
    end else begin
      bus_oe_q  <= (state_d == ST_RUN) || (state_d == ST_REDRIVE);
      clk_oe_q  <= ~i_clkout_float_in_hold || (state_d == ST_RUN) ||
                   (state_d == ST_REDRIVE);
      grant_n_q <= ~(state_d == ST_GRANTED);
    end
  end

  // Strobe pattern for each command; self-refresh is a refresh with CKE low
  always_comb begin
    stb_d     = STB_NOP;
    cke_d     = cke_q;
    selfref_d = selfref_q;
    if (cmd_fire) begin
      unique case (cmd_e'(i_cmd))
        CMD_NOP:       stb_d = STB_NOP;
        CMD_ACTIVATE:  stb_d = STB_ACTIVATE;
        CMD_READ:      stb_d = STB_READ;
        CMD_WRITE:     stb_d = STB_WRITE;
        CMD_PRECHARGE: stb_d = STB_PRECHARGE;
        CMD_REFRESH:   stb_d = STB_REFRESH;
        CMD_MODE_SET:  stb_d = STB_MODE_SET;
        CMD_SELF_REF: begin
          // Entry issues refresh with CKE low; a second one exits
          stb_d     = selfref_q ? STB_NOP : STB_REFRESH;
          cke_d     = selfref_q;
          selfref_d = ~selfref_q;
        end
      endcase
    end
  end

  // Command registers drive the pins for one cycle, then return to idle; CKE and self-refresh state keep their value
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      stb_q     <= STB_NOP;
      cke_q     <= 1'b1;
      selfref_q <= 1'b0;
      wr_q      <= 1'b0;
      ce_n_q    <= '1;
      pdt_n_q   <= 1'b1;
      soe_n_q   <= 1'b1;
    end else begin
      stb_q     <= stb_d;
      cke_q     <= cke_d;
      selfref_q <= selfref_d;
      wr_q      <= cmd_fire & is_write;
      ce_n_q    <= (cmd_fire & ~is_self) ? ~i_cmd_ce : '1;
      pdt_n_q   <= ~(cmd_fire & i_cmd_pdt);
      soe_n_q   <= ~(cmd_fire & (i_cmd == CMD_READ));
    end
  end

  // Address, data and byte enables; no reset needed on the data path
  always_ff @(posedge i_clk) begin
    if (cmd_fire) begin
      addr_q  <= i_cmd_addr;
      wdata_q <= i_cmd_wdata;
      be_n_q  <= ~i_cmd_be;
    end
  end

  // Read data from the pins crosses two flip-flops before use
  always_ff @(posedge i_clk) begin
    rd_meta_q <= i_data_in;
    rd_q      <= rd_meta_q;
  end

  // Shared strobes map row, column and write in that order
  assign o_row_strobe_n         = stb_q[2];
  assign o_column_strobe_n      = stb_q[1];
  assign o_sdram_write_strobe_n = stb_q[0];

  // Narrow instance has no self-refresh, so its CKE stays high
  assign o_sdram_clock_enable = WIDE ? cke_q : 1'b1;
  assign o_self_refresh       = selfref_q;

  assign o_chip_en_n                          = ce_n_q;
  assign o_byte_en_n                          = be_n_q;
  assign o_addr                               = addr_q;
  assign o_data_out                           = wdata_q;
  assign o_rd_data                            = rd_q;
  assign o_second_output_enable_n             = soe_n_q;
  assign o_peripheral_direct_transfer_strobe_n = pdt_n_q;

  // Whole released set shares one enable; data only driven on writes
  assign o_bus_oe   = bus_oe_q;
  assign o_data_oe  = bus_oe_q & wr_q;
  assign o_bus_hold_grant_n = grant_n_q;

  // Output clock pin is the link clock, gated only by its enable
  assign o_memif_clock_output    = i_link_clk;
  assign o_memif_clock_output_oe = clk_oe_q;

  // Request level from a flop, so the crossing never samples a glitch
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= pending;
    end
  end

  // Bus request crosses into the output clock domain as a level
  always_ff @(posedge i_link_clk) begin
    if (i_link_reset) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= pending_q;
      req_sync_q <= req_meta_q;
    end
  end

  assign o_pending_access_request = req_sync_q;

endmodule

`default_nettype wire

// File: test/external_bus_hold_handshake_properties.sv
// Assertion checker for the hold handshake ports
`timescale 1ns/1ps
`default_nettype none
module external_bus_hold_handshake_properties
  import memif_hold_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_hold_req_n,
  input  wire logic       i_hold_inhibit,
  input  wire logic       i_clkout_float_in_hold,
  input  wire logic       i_access_busy,
  input  wire logic       i_cmd_valid,
  input  wire logic [2:0] i_cmd,
  input  wire logic       o_cmd_ready,
  input  wire logic       o_bus_hold_grant_n,
  input  wire logic       o_bus_oe,
  input  wire logic       o_memif_clock_output_oe,
  input  wire logic       o_row_strobe_n,
  input  wire logic       o_column_strobe_n,
  input  wire logic       o_sdram_write_strobe_n
);
  // Strobe triple, ordered row, column, write
  wire logic [2:0] stb;
  wire logic       take;
  assign stb = {o_row_strobe_n, o_column_strobe_n, o_sdram_write_strobe_n};
  assign take = i_cmd_valid && o_cmd_ready;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  AST_FLOAT_MIN: assert property (
      $fell(i_hold_req_n) |-> o_bus_oe[*2])
    else $error("bus floated too early");
  AST_GRANT_AFTER_FLOAT: assert property (
      $fell(o_bus_hold_grant_n) |-> !o_bus_oe)
    else $error("grant before bus release");
  AST_GRANT_WITHIN: assert property (
      $fell(o_bus_oe) |-> ##[0:2] !o_bus_hold_grant_n)
    else $error("grant late after release");
  AST_REDRIVE: assert property (
      $rose(i_hold_req_n) && !o_bus_oe |->
      !o_bus_oe[*2] ##[1:6] o_bus_oe)
    else $error("redrive outside window");
  AST_UNGRANT: assert property (
      $rose(o_bus_oe) |-> ##[0:2] o_bus_hold_grant_n)
    else $error("grant not withdrawn");
  AST_CLK_KEEPS: assert property (
      !o_bus_hold_grant_n && !i_clkout_float_in_hold |->
      o_memif_clock_output_oe)
    else $error("clock stopped in hold");
  AST_CLK_FLOATS: assert property (
      $fell(o_bus_hold_grant_n) && i_clkout_float_in_hold |->
      !o_memif_clock_output_oe)
    else $error("clock driven in hold");
  AST_CLK_FLOAT_MIN: assert property (
      $fell(i_hold_req_n) |-> o_memif_clock_output_oe[*2])
    else $error("clock floated too early");
  AST_INHIBIT: assert property (
      i_hold_inhibit && o_bus_oe |=> o_bus_oe)
    else $error("bus released under inhibit");
  AST_BUSY: assert property (
      i_access_busy && o_bus_oe |=> o_bus_oe)
    else $error("bus released while busy");
  AST_REFRESH: assert property (
      take && i_cmd == CMD_REFRESH |=> stb == STB_REFRESH)
    else $error("bad refresh strobes");
  AST_MODE_SET: assert property (
      take && i_cmd == CMD_MODE_SET |=> stb == STB_MODE_SET)
    else $error("bad mode set strobes");
endmodule
bind external_bus_hold_handshake external_bus_hold_handshake_properties chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_hold_req_n(i_hold_req_n),
  .i_hold_inhibit(i_hold_inhibit),
  .i_clkout_float_in_hold(i_clkout_float_in_hold),
  .i_access_busy(i_access_busy), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
  .o_cmd_ready(o_cmd_ready), .o_bus_hold_grant_n(o_bus_hold_grant_n),
  .o_bus_oe(o_bus_oe), .o_memif_clock_output_oe(o_memif_clock_output_oe),
  .o_row_strobe_n(o_row_strobe_n), .o_column_strobe_n(o_column_strobe_n),
  .o_sdram_write_strobe_n(o_sdram_write_strobe_n));
`default_nettype wire

// File: test/hold_master_model.sv
// Behavioural outside bus master driving the hold request
`timescale 1ns/1ps
`default_nettype none
module hold_master_model (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_want,
  input  wire logic i_grant_n,
  output var logic  o_hold_req_n
);
  logic seen_q;
  // Release only a full clock after the grant was seen low
  always_ff @(posedge i_clk) begin
    seen_q <= !o_hold_req_n && !i_grant_n;
    if (i_reset) o_hold_req_n <= 1'b1;
    else if (i_want) o_hold_req_n <= 1'b0;
    else if (seen_q) o_hold_req_n <= 1'b1;
  end
endmodule
`default_nettype wire

// File: test/external_bus_hold_handshake_tb_top.sv
// Self-checking bench for the hold handshake block
`timescale 1ns/1ps
`default_nettype none
module external_bus_hold_handshake_tb_top import memif_hold_pkg::*;;
  logic clk = 0, lclk = 0, rst = 1, lrst = 1, want = 0, inh = 0, flt = 1;
  logic busy = 0, cv = 0, peripheral_direct_transfer_strobe = 0;
  wire logic n_rdy, n_sref, n_cke, nr_n, nc_n, nw_n, mclk, soe_n, pdt_n;
  wire logic [63:0] rd;
  wire logic [19:0] addr;
  wire logic [7:0] be_n;
  logic [2:0] cmd = 3'h0;
  logic [3:0] ce = 4'h0;
  wire logic req_n, gnt_n, rdy, boe, coe, sref, cke, doe, r_n, c_n, w_n, pend;
  wire logic [3:0] ce_n;
  wire logic [63:0] dout, din;
  int n_mismatch = 0, comparisons = 0, n;
  // Released data bus reads back the inverse, never a stale copy
  assign din = doe ? dout : ~dout;
  initial forever #20 clk = ~clk;
  initial begin
    #7;
    forever #32 lclk = ~lclk;
  end
  external_bus_hold_handshake #(.WIDE(1'b1)) dut (
    .i_clk(clk), .i_reset(rst), .i_link_clk(lclk), .i_link_reset(lrst),
    .i_hold_req_n(req_n), .o_bus_hold_grant_n(gnt_n),
    .o_pending_access_request(pend), .i_hold_inhibit(inh),
    .i_clkout_float_in_hold(flt), .i_cmd_valid(cv), .i_cmd(cmd),
    .i_cmd_addr(20'h0ABCD), .i_cmd_wdata(64'h0123456789ABCDEF),
    .i_cmd_be(8'hFF), .i_cmd_ce(ce), .i_cmd_pdt(peripheral_direct_transfer_strobe), .i_access_busy(busy),
    .o_cmd_ready(rdy), .o_self_refresh(sref), .o_rd_data(rd),
    .o_chip_en_n(ce_n), .o_byte_en_n(be_n), .o_addr(addr), .o_data_out(dout),
    .o_data_oe(doe), .i_data_in(din), .o_row_strobe_n(r_n),
    .o_column_strobe_n(c_n), .o_sdram_write_strobe_n(w_n),
    .o_sdram_clock_enable(cke), .o_second_output_enable_n(soe_n),
    .o_peripheral_direct_transfer_strobe_n(pdt_n), .o_bus_oe(boe),
    .o_memif_clock_output(mclk), .o_memif_clock_output_oe(coe));
  hold_master_model master (.i_clk(clk), .i_reset(rst), .i_want(want),
    .i_grant_n(gnt_n), .o_hold_req_n(req_n));
  // Narrow instance shares the command port; it must refuse self-refresh
  external_bus_hold_handshake #(.WIDE(1'b0)) dut_narrow (
    .i_clk(clk), .i_reset(rst), .i_link_clk(lclk), .i_link_reset(lrst),
    .i_hold_req_n(1'b1), .o_bus_hold_grant_n(),
    .o_pending_access_request(), .i_hold_inhibit(1'b0),
    .i_clkout_float_in_hold(1'b0), .i_cmd_valid(cv), .i_cmd(cmd),
    .i_cmd_addr(20'h0ABCD), .i_cmd_wdata(16'h89AB), .i_cmd_be(2'h3),
    .i_cmd_ce(ce), .i_cmd_pdt(1'b0), .i_access_busy(1'b0),
    .o_cmd_ready(n_rdy), .o_self_refresh(n_sref), .o_rd_data(),
    .o_chip_en_n(), .o_byte_en_n(), .o_addr(), .o_data_out(),
    .o_data_oe(), .i_data_in(16'h0000), .o_row_strobe_n(nr_n),
    .o_column_strobe_n(nc_n), .o_sdram_write_strobe_n(nw_n),
    .o_sdram_clock_enable(n_cke), .o_second_output_enable_n(),
    .o_peripheral_direct_transfer_strobe_n(), .o_bus_oe(),
    .o_memif_clock_output(), .o_memif_clock_output_oe());
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Bounded wait for the grant level; a timeout ends the run
  task automatic wait_gnt(input logic lvl);
    for (n = 1; n <= 20; n++) begin
      @(negedge clk);
      if (gnt_n === lvl) return;
    end
    n_mismatch++;
    final_report();
  endtask
  task automatic send(input logic [2:0] c);
    @(posedge clk);
    cv <= 1'b1;
    cmd <= c;
    ce <= 4'h2;
    peripheral_direct_transfer_strobe <= (c == CMD_WRITE);
    @(posedge clk);
    cv <= 1'b0;
    @(negedge clk);
  endtask
  task automatic issue(input logic [2:0] c, input logic [2:0] exp);
    send(c);
    chk({r_n, c_n, w_n}, exp);
    chk({nr_n, nc_n, nw_n}, exp);
    chk(ce_n, 4'hD);
    chk({soe_n, pdt_n, doe},
        {c != CMD_READ, c != CMD_WRITE, c == CMD_WRITE});
  endtask
  // Every strobe command, refresh and mode set included
  task automatic sc_cmds();
    issue(CMD_ACTIVATE, STB_ACTIVATE);
    issue(CMD_READ, STB_READ);
    issue(CMD_WRITE, STB_WRITE);
    issue(CMD_PRECHARGE, STB_PRECHARGE);
    issue(CMD_REFRESH, STB_REFRESH);
    issue(CMD_MODE_SET, STB_MODE_SET);
  endtask
  // Self-refresh entry and exit on the wide instance
  task automatic sc_selfref();
    send(CMD_SELF_REF);
    chk({sref, cke}, 2'h2);
    chk({rdy, n_rdy, n_sref, n_cke}, 4'h9);
    chk(rd, 64'hFEDCBA9876543210);
    chk({addr, be_n}, {20'h0ABCD, 8'h00});
    send(CMD_SELF_REF);
    chk({sref, cke}, 2'h1);
  endtask
  // Idle hold with the output clock floating or toggling
  task automatic sc_hold(input logic f);
    @(posedge clk);
    flt <= f;
    want <= 1'b1;
    wait_gnt(1'b0);
    chk(n, 6);
    chk({boe, coe, rdy}, {1'b0, !f, 1'b0});
    chk(mclk, lclk);
    @(posedge clk);
    want <= 1'b0;
    wait_gnt(1'b1);
    chk({n >= 5 && n <= 10, boe, coe}, 3'h7);
  endtask
  // Hold held off by a busy bus or by the inhibit control
  task automatic sc_block(input logic b, input logic i);
    @(posedge clk);
    busy <= b;
    inh <= i;
    want <= 1'b1;
    repeat (12) @(negedge clk);
    chk({gnt_n, boe, pend}, {2'h3, b});
    @(posedge clk);
    busy <= 1'b0;
    inh <= 1'b0;
    wait_gnt(1'b0);
    chk(n, 3);
    // Bus request needs the crossing's latency before it drops
    repeat (6) @(negedge clk);
    chk({gnt_n, pend}, 2'h0);
    @(posedge clk);
    want <= 1'b0;
    wait_gnt(1'b1);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    lrst <= 1'b0;
    sc_cmds();
    sc_selfref();
    sc_hold(1'b1);
    sc_hold(1'b0);
    sc_block(1'b1, 1'b0);
    sc_block(1'b0, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
